// ---- hw/itp_pkg.sv ----
// package: constants, register layout and carrier types for the pwm/relay stage
package itp_pkg;
  // clock and modulator tick
  localparam int CLK_MHZ = 125;
  localparam int TICK_US = 50;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  // frame layout in ticks (2048-tick frame, 102.4 ms)
  localparam int DUTY_BITS = 10;
  localparam logic [11:0] FRAME_TICKS = 12'h0800;
  localparam logic [11:0] LEAD_TICKS = 12'h0100;
  localparam logic [11:0] DATA_TICKS = 12'h0400;
  localparam logic [11:0] ERR_TICKS = 12'h0200;
  // temperature register layout
  localparam int DATA_MSB = 15;
  localparam int DATA_LSB = 4;
  localparam int OVH_BIT = 3;
  localparam int OVL_BIT = 2;
  localparam int FE_BIT = 1;
  localparam logic [11:0] CODE_MIN = 12'h000;
  localparam logic [11:0] CODE_MAX = 12'hFFF;
  // avalon register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_THRESH = 8'h04;
  localparam logic [7:0] OFS_HYST = 8'h08;
  localparam logic [7:0] OFS_OBJ = 8'h0C;
  localparam logic [7:0] OFS_AMB = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  // ctrl bits and reset values
  localparam int CTRL_SRC_BIT = 0;
  localparam int CTRL_POL_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [11:0] THRESH_RST = 12'h0D24;
  localparam logic [11:0] HYST_RST = 12'h0092;
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

  // raw sample from linearisation chain
  typedef struct packed {
    logic [11:0] code;
    logic below;
    logic above;
  } itp_raw_t;

  // conditioned temperature word
  typedef struct packed {
    logic [11:0] code;
    logic ambient_overflow_flag;
    logic ambient_underflow_flag;
    logic fe;
  } itp_temp_t;

  function automatic logic [15:0] pack_reg(input itp_temp_t t);
    pack_reg = {t.code, t.ambient_overflow_flag, t.ambient_underflow_flag, t.fe, 1'b0};
  endfunction
endpackage

// ---- hw/itp_pwm_frame.sv ----
// one pwm frame generator: lead, high, low, trail, error pattern
`timescale 1ns/1ps
module itp_pwm_frame (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // tick and data
  input wire logic tick,
  input wire logic [11:0] code,
  input wire logic err,
  // output
  output logic pwm_out
);
  logic [11:0] cnt_r, cnt_nxt;
  logic [9:0] high_r, high_nxt;
  logic err_r, err_nxt;
  logic pwm_r, pwm_nxt;
  logic [11:0] high_end;

  assign high_end = itp_pkg::LEAD_TICKS + {2'b00, high_r};
  assign pwm_out = pwm_r;

  // frame counter; high time latched at frame start
  always_comb begin
    cnt_nxt = cnt_r;
    high_nxt = high_r;
    err_nxt = err_r;
    pwm_nxt = pwm_r;
    if (tick) begin
      if (cnt_r == itp_pkg::FRAME_TICKS - 12'h001) begin
        cnt_nxt = 12'h000;
        high_nxt = code[11:2];
        err_nxt = err;
      end else begin
        cnt_nxt = cnt_r + 12'h001;
      end
    end
    // waveform by phase
    if (err_r) begin
      pwm_nxt = (cnt_r >= itp_pkg::LEAD_TICKS) &&
                (cnt_r < itp_pkg::LEAD_TICKS + itp_pkg::ERR_TICKS);
    end else if (cnt_r < itp_pkg::LEAD_TICKS) begin
      pwm_nxt = 1'b0;
    end else if (cnt_r < high_end) begin
      pwm_nxt = 1'b1;
    end else begin
      pwm_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 12'h000;
      high_r <= 10'h000;
      err_r <= 1'b0;
      pwm_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      high_r <= high_nxt;
      err_r <= err_nxt;
      pwm_r <= pwm_nxt;
    end
  end

  // no high time in the leading buffer
  property p_lead_low;
    @(posedge ref_clk) disable iff (!rstn)
      (cnt_r < itp_pkg::LEAD_TICKS) |=> !pwm_r;
  endproperty
  a_lead_low: assert property (p_lead_low)
    else $error("pwm high in leading buffer");

  // data high never reaches the trailing part of the frame
  property p_trail_low;
    @(posedge ref_clk) disable iff (!rstn)
      (!err_r && cnt_r >= itp_pkg::LEAD_TICKS + itp_pkg::DATA_TICKS)
      |=> !pwm_r;
  endproperty
  a_trail_low: assert property (p_trail_low)
    else $error("pwm high after data portion");

  c_high: cover property (@(posedge ref_clk) disable iff (!rstn)
    $rose(pwm_r));
endmodule

// ---- hw/itp_relay_cmp.sv ----
// relay comparator with hysteresis; polarity is applied in itp_top
`timescale 1ns/1ps
module itp_relay_cmp (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // settings
  input wire logic [11:0] temp,
  input wire logic [11:0] thresh,
  input wire logic [11:0] hyst,
  // result
  output logic above
);
  logic above_r, above_nxt;
  logic [12:0] lo;

  assign lo = {1'b0, thresh} - {1'b0, hyst};
  assign above = above_r;

  // above sets over threshold, clears below threshold minus hysteresis, or at or below threshold when hysteresis exceeds it
  always_comb begin
    above_nxt = above_r;
    if (temp > thresh) begin
      above_nxt = 1'b1;
    end else if (lo[12] || {1'b0, temp} < lo) begin
      above_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      above_r <= 1'b0;
    end else begin
      above_r <= above_nxt;
    end
  end
endmodule

// ---- hw/itp_top.sv ----
// pwm temperature outputs, relay comparator and avalon registers
// What this block does
// - 10-bit modulator on 50 us tick
// - 12.5 percent leading buffer each frame
// - 37.5 percent trailing buffer each frame
// - high portion 0 to 50 percent
// - ambient pin duty linear in ambient
// - 12-bit digital magnitude comparator
// - polarity resets to inverting
// - inverting: relay off above threshold
// - non-inverting: relay on above threshold
// - threshold held in writable configuration
// - hysteresis around threshold, preset 95/5
// - object out of range clamps 000/FFF
// - ambient register updates despite object range
// - ambient out of range clamps, sets flag
// - bit 3 overflow flag, data all ones
// - bit 2 underflow, bit 1 fatal, bit 0 zero
`timescale 1ns/1ps
module itp_top #(
  parameter int TICK_CYCLES = itp_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // samples from the linearisation chain
  input wire logic obj_valid,
  input wire itp_pkg::itp_raw_t obj_raw,
  input wire itp_pkg::itp_raw_t amb_raw,
  input wire logic nvm_fatal,
  // output pins
  output logic obj_pwm_out,
  output logic amb_pwm_out,
  output logic relay_driver_out,
  output logic relay_driver_oe_n
);
  // tick divider
  logic [15:0] tick_cnt_r, tick_cnt_nxt;
  logic tick_r, tick_nxt;
  // configuration
  logic src_amb_r, src_amb_nxt;
  logic noninv_r, noninv_nxt;
  logic [11:0] thresh_r, thresh_nxt;
  logic [11:0] hyst_r, hyst_nxt;
  // temperature registers
  itp_pkg::itp_temp_t obj_r, obj_nxt, amb_r, amb_nxt;
  // bus
  logic ack_r, ack_nxt;
  logic wait_r, wait_nxt;
  logic [31:0] rd_r, rd_nxt;
  // relay
  logic rel_on_r, rel_on_nxt;
  logic above;
  logic pwm_obj, pwm_amb;

  // tick generator, about 50 us
  always_comb begin
    tick_nxt = 1'b0;
    tick_cnt_nxt = tick_cnt_r + 16'h0001;
    if (tick_cnt_r == 16'(TICK_CYCLES - 1)) begin
      tick_cnt_nxt = 16'h0000;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  // temperature conditioning: clamps and flags
  always_comb begin
    obj_nxt = obj_r;
    amb_nxt = amb_r;
    if (obj_valid) begin
      amb_nxt.code = amb_raw.code;
      amb_nxt.ambient_overflow_flag = amb_raw.above;
      amb_nxt.ambient_underflow_flag = amb_raw.below;
      amb_nxt.fe = nvm_fatal;
      if (amb_raw.above) begin
        amb_nxt.code = itp_pkg::CODE_MAX;
      end else if (amb_raw.below) begin
        amb_nxt.code = itp_pkg::CODE_MIN;
      end
      obj_nxt.ambient_overflow_flag = amb_raw.above;
      obj_nxt.ambient_underflow_flag = amb_raw.below;
      obj_nxt.fe = nvm_fatal;
      if (amb_raw.above) begin
        obj_nxt.code = itp_pkg::CODE_MAX;
      end else if (amb_raw.below) begin
        obj_nxt.code = itp_pkg::CODE_MIN;
      end else if (obj_raw.above) begin
        obj_nxt.code = itp_pkg::CODE_MAX;
      end else if (obj_raw.below) begin
        obj_nxt.code = itp_pkg::CODE_MIN;
      end else begin
        obj_nxt.code = obj_raw.code;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      obj_r <= '0;
      amb_r <= '0;
    end else begin
      obj_r <= obj_nxt;
      amb_r <= amb_nxt;
    end
  end

  // avalon slave: one wait cycle, then answer
  always_comb begin
    src_amb_nxt = src_amb_r;
    noninv_nxt = noninv_r;
    thresh_nxt = thresh_r;
    hyst_nxt = hyst_r;
    ack_nxt = (avs_read | avs_write) & ~ack_r;
    wait_nxt = ~ack_nxt; // waitrequest kept in its own flop
    rd_nxt = rd_r;
    if (avs_write && !ack_r && avs_byteenable[0]) begin
      unique case (avs_address)
        itp_pkg::OFS_CTRL: begin
          src_amb_nxt = avs_writedata[itp_pkg::CTRL_SRC_BIT];
          noninv_nxt = avs_writedata[itp_pkg::CTRL_POL_BIT];
        end
        itp_pkg::OFS_THRESH: begin
          thresh_nxt[7:0] = avs_writedata[7:0];
        end
        itp_pkg::OFS_HYST: begin
          hyst_nxt[7:0] = avs_writedata[7:0];
        end
        default: begin
        end
      endcase
    end
    if (avs_write && !ack_r && avs_byteenable[1]) begin
      if (avs_address == itp_pkg::OFS_THRESH) begin
        thresh_nxt[11:8] = avs_writedata[11:8];
      end
      if (avs_address == itp_pkg::OFS_HYST) begin
        hyst_nxt[11:8] = avs_writedata[11:8];
      end
    end
    if (avs_read && !ack_r) begin
      unique case (avs_address)
        itp_pkg::OFS_CTRL: rd_nxt = {30'h0, noninv_r, src_amb_r};
        itp_pkg::OFS_THRESH: rd_nxt = {20'h0_0000, thresh_r};
        itp_pkg::OFS_HYST: rd_nxt = {20'h0_0000, hyst_r};
        itp_pkg::OFS_OBJ: rd_nxt = {16'h0000, itp_pkg::pack_reg(obj_r)};
        itp_pkg::OFS_AMB: rd_nxt = {16'h0000, itp_pkg::pack_reg(amb_r)};
        itp_pkg::OFS_STAT: rd_nxt = {31'h0, rel_on_r};
        default: rd_nxt = itp_pkg::UNMAPPED_RD;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      src_amb_r <= itp_pkg::CTRL_RST[itp_pkg::CTRL_SRC_BIT];
      noninv_r <= itp_pkg::CTRL_RST[itp_pkg::CTRL_POL_BIT];
      thresh_r <= itp_pkg::THRESH_RST;
      hyst_r <= itp_pkg::HYST_RST;
      ack_r <= 1'b0;
      wait_r <= 1'b1;
      rd_r <= 32'h0000_0000;
    end else begin
      src_amb_r <= src_amb_nxt;
      noninv_r <= noninv_nxt;
      thresh_r <= thresh_nxt;
      hyst_r <= hyst_nxt;
      ack_r <= ack_nxt;
      wait_r <= wait_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata = rd_r;

  // comparator on the selected source
  itp_relay_cmp u_cmp (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .temp(src_amb_r ? amb_r.code : obj_r.code),
    .thresh(thresh_r),
    .hyst(hyst_r),
    .above(above)
  );

  // relay drive by polarity
  always_comb begin
    rel_on_nxt = noninv_r ? above : ~above;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rel_on_r <= 1'b0;
    end else begin
      rel_on_r <= rel_on_nxt;
    end
  end

  // open drain: low output, enable low while sinking
  assign relay_driver_out = 1'b0;
  assign relay_driver_oe_n = ~rel_on_r;

  // pwm outputs
  itp_pwm_frame u_obj (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .tick(tick_r),
    .code(obj_r.code),
    .err(obj_r.fe),
    .pwm_out(pwm_obj)
  );

  itp_pwm_frame u_amb (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .tick(tick_r),
    .code(amb_r.code),
    .err(amb_r.fe),
    .pwm_out(pwm_amb)
  );

  assign obj_pwm_out = pwm_obj;
  assign amb_pwm_out = pwm_amb;

  property p_inv_off;
    @(posedge ref_clk) disable iff (!rstn)
      (!noninv_r && above) |=> !rel_on_r;
  endproperty
  a_inv_off: assert property (p_inv_off) else $error("relay on");

  property p_noninv_on;
    @(posedge ref_clk) disable iff (!rstn)
      (noninv_r && above) |=> rel_on_r;
  endproperty
  a_noninv_on: assert property (p_noninv_on)
    else $error("relay off");

  property p_ovh_clamp;
    @(posedge ref_clk) disable iff (!rstn)
      obj_r.ambient_overflow_flag |-> obj_r.code == itp_pkg::CODE_MAX;
  endproperty
  a_ovh_clamp: assert property (p_ovh_clamp)
    else $error("overflow not clamped");

  property p_ovl_clamp;
    @(posedge ref_clk) disable iff (!rstn)
      obj_r.ambient_underflow_flag |-> obj_r.code == itp_pkg::CODE_MIN;
  endproperty
  a_ovl_clamp: assert property (p_ovl_clamp)
    else $error("underflow not clamped");

  // ambient word clamps with its own flags as well
  property p_amb_ovh;
    @(posedge ref_clk) disable iff (!rstn)
      amb_r.ambient_overflow_flag |-> amb_r.code == itp_pkg::CODE_MAX;
  endproperty
  a_amb_ovh: assert property (p_amb_ovh)
    else $error("ambient overflow not clamped");

  property p_amb_ovl;
    @(posedge ref_clk) disable iff (!rstn)
      amb_r.ambient_underflow_flag |-> amb_r.code == itp_pkg::CODE_MIN;
  endproperty
  a_amb_ovl: assert property (p_amb_ovl)
    else $error("ambient underflow not clamped");

  property p_ack;
    @(posedge ref_clk) disable iff (!rstn)
      (avs_read && avs_waitrequest) |=> !avs_waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("no bus answer");

  property p_wr_thresh;
    @(posedge ref_clk) disable iff (!rstn)
      (avs_write && !ack_r && avs_address == itp_pkg::OFS_THRESH &&
       avs_byteenable[1:0] == 2'b11) |=> thresh_r == $past(avs_writedata[11:0]);
  endproperty
  a_wr_thresh: assert property (p_wr_thresh)
    else $error("threshold not stored");

  c_relay_on: cover property (@(posedge ref_clk) $rose(rel_on_r));
  c_ovh: cover property (@(posedge ref_clk) obj_r.ambient_overflow_flag);
  c_rd: cover property (@(posedge ref_clk) avs_read && !avs_waitrequest);
endmodule

// ---- verif/itp_rx_model.sv ----
// far-side model: pwm receiver timing capture and pulled-up relay line
`timescale 1ns/1ps
module itp_rx_model (
  // clock
  input wire logic ref_clk,
  // pins from the block
  input wire logic pwm_in,
  input wire logic relay_drv,
  input wire logic relay_oe_n,
  // what the far side sees
  output logic relay_line,
  output logic [15:0] hi_cyc,
  output logic [15:0] per_cyc,
  output logic [7:0] n_rise
);
  logic [15:0] hcnt;
  logic [15:0] pcnt;
  logic last;
  // load pull-up wins whenever the driver floats
  assign relay_line = relay_oe_n ? 1'b1 : relay_drv;
  // start from a quiet line
  initial begin
    hcnt = 16'h0000;
    pcnt = 16'h0000;
    last = 1'b0;
    hi_cyc = 16'h0000;
    per_cyc = 16'h0000;
    n_rise = 8'h00;
  end
  // high time of each pulse and rise-to-rise period, in clocks
  always @(posedge ref_clk) begin
    if (pwm_in === 1'b1 && last === 1'b0) begin
      per_cyc <= pcnt + 16'h0001;
      pcnt <= 16'h0000;
      hcnt <= 16'h0001;
      n_rise <= n_rise + 8'h01;
    end else begin
      pcnt <= pcnt + 16'h0001;
      if (pwm_in === 1'b1) hcnt <= hcnt + 16'h0001;
    end
    if (pwm_in === 1'b0 && last === 1'b1) hi_cyc <= hcnt;
    last <= pwm_in;
  end
endmodule

// ---- verif/tb_top.sv ----
// testbench: registers, relay comparator and pwm frames of the output stage
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic obj_valid = 1'b0;
  itp_pkg::itp_raw_t obj_raw = '0;
  itp_pkg::itp_raw_t amb_raw = '0;
  logic nvm_fatal = 1'b0;
  logic obj_pwm_out, amb_pwm_out, relay_driver_out, relay_driver_oe_n;
  logic relay_line;
  logic [15:0] o_hi, o_per, a_hi, a_per;
  logic [7:0] o_n;
  int fails = 0;
  int checks = 0;

  // 125 MHz clock
  always #4 ref_clk = ~ref_clk;

  itp_top #(.TICK_CYCLES(2)) dut (.ref_clk(ref_clk), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .obj_valid(obj_valid), .obj_raw(obj_raw), .amb_raw(amb_raw),
    .nvm_fatal(nvm_fatal), .obj_pwm_out(obj_pwm_out),
    .amb_pwm_out(amb_pwm_out), .relay_driver_out(relay_driver_out),
    .relay_driver_oe_n(relay_driver_oe_n));
  itp_rx_model obj_rx (.ref_clk(ref_clk), .pwm_in(obj_pwm_out),
    .relay_drv(relay_driver_out), .relay_oe_n(relay_driver_oe_n),
    .relay_line(relay_line), .hi_cyc(o_hi), .per_cyc(o_per), .n_rise(o_n));
  itp_rx_model amb_rx (.ref_clk(ref_clk), .pwm_in(amb_pwm_out),
    .relay_drv(relay_driver_out), .relay_oe_n(relay_driver_oe_n),
    .relay_line(), .hi_cyc(a_hi), .per_cyc(a_per), .n_rise());

  // avalon write, held until waitrequest is seen low
  task automatic avm_wr(input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= 4'h3;
    avs_write <= 1'b1; // strobe selects the block while held
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask

  // avalon read and compare
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    `CHK(d, e)
    @(posedge ref_clk);
  endtask

  // new samples from the chain, flags given as {below, above}
  task automatic set_s(input logic [11:0] oc, input logic [1:0] of,
                       input logic [11:0] ac, input logic [1:0] af,
                       input logic fe);
    obj_raw <= {oc, of};
    amb_raw <= {ac, af};
    nvm_fatal <= fe;
    obj_valid <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask

  // relay state on the pulled-up line and in status
  task automatic rel_chk(input logic on);
    int k;
    k = 0;
    while (relay_line !== ~on && k < 32) begin
      @(posedge ref_clk);
      k++;
    end
    `CHK(relay_line, ~on)
    rd_chk(itp_pkg::OFS_STAT, {31'h0, on});
  endtask

  // let whole frames pass so latched lengths take effect
  task automatic frames(input int n);
    logic [7:0] s;
    int k;
    s = o_n;
    k = 0;
    while (int'(8'(o_n - s)) < n && k < 20000) begin
      @(posedge ref_clk);
      k++;
    end
  endtask

  // verdict and end of run
  task automatic report_and_stop();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (80000) @(posedge ref_clk);
    fails++;
    report_and_stop();
  end

  // main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    // reset values, unmapped space
    rd_chk(itp_pkg::OFS_CTRL, 32'h0000_0000);
    rd_chk(itp_pkg::OFS_THRESH, 32'h0000_0D24);
    rd_chk(itp_pkg::OFS_HYST, 32'h0000_0092);
    avm_wr(8'h1C, 32'h0000_FFFF);
    rd_chk(8'h1C, 32'h0000_0000);
    // register word: normal, read-only, object and ambient clamps
    set_s(12'h0123, 2'b00, 12'h0456, 2'b00, 1'b0);
    rd_chk(itp_pkg::OFS_OBJ, 32'h0000_1230);
    avm_wr(itp_pkg::OFS_OBJ, 32'h0000_5555);
    rd_chk(itp_pkg::OFS_OBJ, 32'h0000_1230);
    set_s(12'h0123, 2'b10, 12'h0456, 2'b00, 1'b0);
    rd_chk(itp_pkg::OFS_OBJ, 32'h0000_0000);
    rd_chk(itp_pkg::OFS_AMB, 32'h0000_4560);
    set_s(12'h0123, 2'b01, 12'h0456, 2'b00, 1'b0);
    rd_chk(itp_pkg::OFS_OBJ, 32'h0000_FFF0);
    set_s(12'h0123, 2'b00, 12'h0456, 2'b01, 1'b0);
    rd_chk(itp_pkg::OFS_OBJ, 32'h0000_FFF8);
    rd_chk(itp_pkg::OFS_AMB, 32'h0000_FFF8);
    set_s(12'h0123, 2'b00, 12'h0456, 2'b10, 1'b0);
    rd_chk(itp_pkg::OFS_OBJ, 32'h0000_0004);
    set_s(12'h0123, 2'b00, 12'h0456, 2'b00, 1'b1);
    rd_chk(itp_pkg::OFS_OBJ, 32'h0000_1232);
    // relay: inverting, object source, band 0xC92..0xD24
    set_s(12'h0E00, 2'b00, 12'h0456, 2'b00, 1'b0);
    rel_chk(1'b0);
    set_s(12'h0D00, 2'b00, 12'h0456, 2'b00, 1'b0);
    rel_chk(1'b0);
    set_s(12'h0C00, 2'b00, 12'h0456, 2'b00, 1'b0);
    rel_chk(1'b1);
    set_s(12'h0D00, 2'b00, 12'h0456, 2'b00, 1'b0);
    rel_chk(1'b1);
    avm_wr(itp_pkg::OFS_CTRL, 32'h0000_0002);
    rel_chk(1'b0);
    set_s(12'h0E00, 2'b00, 12'h0456, 2'b00, 1'b0);
    rel_chk(1'b1);
    // ambient source and a new threshold
    set_s(12'h0100, 2'b00, 12'h0456, 2'b00, 1'b0);
    avm_wr(itp_pkg::OFS_CTRL, 32'h0000_0003);
    rel_chk(1'b0);
    avm_wr(itp_pkg::OFS_THRESH, 32'h0000_0300);
    rd_chk(itp_pkg::OFS_THRESH, 32'h0000_0300);
    rel_chk(1'b1);
    // pwm frames: linear high time, fixed period
    set_s(12'h0400, 2'b00, 12'h0800, 2'b00, 1'b0);
    frames(3);
    `CHK(o_hi, 16'h0200)
    `CHK(o_per, 16'h1000)
    `CHK(a_hi, 16'h0400)
    `CHK(a_per, 16'h1000)
    // smallest step and full-scale bound
    set_s(12'h0004, 2'b00, 12'h0FFF, 2'b00, 1'b0);
    frames(3);
    `CHK(o_hi, 16'h0002)
    `CHK(a_hi, 16'h07FE)
    `CHK(a_hi <= 16'h0800, 1'b1)
    `CHK((a_per - a_hi) >= 16'h0400, 1'b1)
    // error pattern
    set_s(12'h0400, 2'b00, 12'h0800, 2'b00, 1'b1);
    frames(3);
    `CHK(o_hi, 16'h0400)
    `CHK(a_hi, 16'h0400)
    report_and_stop();
  end
endmodule
